// ---- bench/fcin_host_model.sv ----
// Purpose: host side of the config/interrupt pin and the first host command
// Assumes: inputs of the partner change just after the rising clock edge
// Notes:   a floating pin shows the inverse of its last value each cycle
`timescale 1ns/100ps
`default_nettype none
module fcin_host_model
  import fcin_pkg::*;
(
  // clock
  input  wire logic CLK,
  // board set-up
  input  wire logic ext_pu,
  input  wire logic unstable,
  // pin and host command
  input  wire logic oe,
  input  wire logic go,
  output var  logic pin,
  output var  logic cmd_stb,
  output var  logic trig
);
  // ***************************************************
  // pin level and command
  // ***************************************************
  initial begin
    pin     = 1'h0;
    cmd_stb = 1'h0;
    trig    = 1'h0;
  end
  // the external pull-up is stronger than the weak pull-down
  always @(posedge CLK) begin
    pin     <= unstable ? ~pin : (ext_pu ? 1'h1 : (oe ? 1'h0 : ~pin));
    cmd_stb <= go;
    trig    <= go;
  end
endmodule
`default_nettype wire

// ---- bench/tb_failure_config_init_normal_ctrl.sv ----
// Purpose: self-checking bench of the failure configuration and init/normal controller
// Assumes: short reset delay and long window counts given as parameters
// Notes:   supply and host behaviour are driven by hand per scenario
`timescale 1ns/100ps
`default_nettype none
module tb_failure_config_init_normal_ctrl
  import fcin_pkg::*;
;
  // short counts keep the run small; filter needs fewer cycles than RD
  localparam int RD = 100;
  localparam int LW = 400;
  logic              clk, rst, above, ov, cfg_in, spi, wdt, wdf, fclr, por, sw, oven, fot;
  logic [WAKE_W-1:0] wake;
  logic              cfg_out, cfg_oe, ro_n, fo_n, hwc, latched_pin_config_bit, ovf, uvf, r2off, r3off;
  logic [1:0]        mode, wdc;
  logic              ext_pu, unst, go;
  int                failures, check_count, i;
  // ***************************************************
  // instances
  // ***************************************************
  fcin_ctrl #(.RD_CYC(CNT_W'(RD)), .LW_CYC(CNT_W'(LW))) i_fcin_ctrl (
    .CLK(clk), .RST(rst), .MAIN_ABOVE_RT(above), .MAIN_OV(ov), .CFG_INT_IN(cfg_in),
    .CFG_INT_OUT(cfg_out), .CFG_INT_OE(cfg_oe), .SPI_CMD_STB(spi), .WD_TRIG(wdt),
    .WD_FAIL(wdf), .FLAG_CLR(fclr), .POR_FLAG(por), .SW_CFG(sw), .MAIN_OV_RST_EN(oven),
    .FO_TEST(fot), .WAKE_EVT(wake), .RESET_OUT_N(ro_n), .FAIL_OUT_N(fo_n), .MODE(mode),
    .HARDWARE_CONTROL_REG_CFG(hwc), .WK_LVL_LATCHED_PIN_CONFIG_BIT(latched_pin_config_bit), .MAIN_OV_FLAG(ovf), .MAIN_UV_FLAG(uvf),
    .WD_FAIL_CNT(wdc), .REG2_HS_OFF(r2off), .REG3_CAN_LIN_OFF(r3off));
  fcin_host_model i_fcin_host_model (
    .CLK(clk), .ext_pu(ext_pu), .unstable(unst), .oe(cfg_oe), .go(go),
    .pin(cfg_in), .cmd_stb(spi), .trig(wdt));
  // ***************************************************
  // helpers
  // ***************************************************
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_ro();
    for (int k = 0; k < 400 && ro_n !== 1'h1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(ro_n, 1'h1);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int k = 0; k < 400 && mode !== m; k++) begin
      @(posedge clk);
      #1;
    end
    chk_code(mode, m);
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic power_up(input logic pu, input logic un);
    @(posedge clk);
    rst <= 1'h1; above <= 1'h0; ext_pu <= pu; unst <= un; oven <= 1'h0; ov <= 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    #1;
    chk(ro_n, 1'h0);
    chk(uvf, 1'h0);
    chk(fo_n, 1'h1);
    @(posedge clk);
    above <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    chk(cfg_oe, 1'h1);
    chk(cfg_out, 1'h0);
    chk_code(mode, MD_INIT);
    wait_ro();
    chk(cfg_oe, 1'h0);
    chk(latched_pin_config_bit, pu & !un);
    chk(uvf, 1'h0);
  endtask
  task automatic init_exit();
    @(posedge clk); wake <= 6'h3f;
    @(posedge clk); wake <= 6'h00;
    repeat (2) @(posedge clk); #1;
    chk(cfg_oe, 1'h0);
    chk_code(mode, MD_INIT);
    @(posedge clk); go <= 1'h1;
    @(posedge clk); go <= 1'h0;
    @(posedge clk); #1;
    chk_code(mode, MD_NORMAL);
    chk(r2off, 1'h1);
    chk(r3off, 1'h1);
    chk(fo_n, 1'h1);
    @(posedge clk); #1;
    chk(cfg_oe, 1'h0);
    chk(r3off, 1'h0);
  endtask
  task automatic wd_fail(input int n, input logic cp);
    logic [1:0] em;
    em = (cp || (!sw && n == 1)) ? MD_RESTART : MD_FAILSAFE;
    @(posedge clk); wdf <= 1'h1;
    @(posedge clk); wdf <= 1'h0; #1;
    chk(ro_n, 1'h0);
    chk_code(wdc, n[1:0]);
    chk_code(mode, em);
    chk(fo_n, !(sw || n == 2));
  endtask
  task automatic recover(input logic fo_exp);
    if (mode === MD_FAILSAFE) begin
      @(posedge clk); wake <= 6'h01;
      @(posedge clk); wake <= 6'h00; #1;
      chk_code(mode, MD_RESTART);
    end
    wait_mode(MD_NORMAL);
    chk(ro_n, 1'h1);
    chk(r2off, 1'h1);
    chk(r3off, 1'h0);
    chk(fo_n, fo_exp);
  endtask
  task automatic ov_event(input logic en, input logic cp);
    @(posedge clk); oven <= en; ov <= 1'h1;
    repeat (5) @(posedge clk); #1;
    chk(ovf, 1'h1);
    chk(fo_n, !en);
    chk(ro_n, !en);
    chk_code(mode, !en ? MD_NORMAL : (cp ? MD_RESTART : MD_FAILSAFE));
    @(posedge clk); ov <= 1'h0; fclr <= 1'h1;
    @(posedge clk); fclr <= 1'h0;
  endtask
  task automatic fo_and_wake();
    @(posedge clk); fot <= 1'h1;
    repeat (3) @(posedge clk); #1;
    chk(fo_n, 1'h1);
    @(posedge clk); fot <= 1'h0;
    init_exit();
    @(posedge clk); fot <= 1'h1;
    @(posedge clk); fot <= 1'h0; #1;
    chk(fo_n, 1'h0);
    @(posedge clk); #1;
    chk(fo_n, 1'h1);
    @(posedge clk); wake <= 6'h20;
    @(posedge clk); wake <= 6'h00;
    repeat (2) @(posedge clk); #1;
    chk(cfg_oe, 1'h1);
    chk_code(mode, MD_NORMAL);
    repeat (INT_PULSE_CYC + 4) @(posedge clk); #1;
    chk(cfg_oe, 1'h0);
  endtask
  task automatic timeout_relatch();
    power_up(1'h1, 1'h0);
    @(posedge clk); ext_pu <= 1'h0; sw <= 1'h0;
    repeat (LW + 20) @(posedge clk); #1;
    chk_code(mode, MD_RESTART);
    chk_code(wdc, 2'h1);
    chk(ro_n, 1'h0);
    recover(1'h1);
    chk(latched_pin_config_bit, 1'h1);
    @(posedge clk); por <= 1'h1;
    wd_fail(2, 1'h1);
    repeat (5) @(posedge clk); #1;
    chk(cfg_oe, 1'h1);
    recover(1'h0);
    chk(latched_pin_config_bit, 1'h0);
    @(posedge clk); por <= 1'h0;
  endtask
  // ***************************************************
  // clock, sequence and watchdog
  // ***************************************************
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 60000);
    failures++;
    wrap_up();
  end
  initial begin
    rst = 1'h1; above = 1'h0; ov = 1'h0; wdf = 1'h0; fclr = 1'h0; por = 1'h0;
    sw = 1'h0; oven = 1'h0; fot = 1'h0; wake = 6'h00; ext_pu = 1'h0; unst = 1'h0; go = 1'h0;
    failures = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    power_up(1'h1, 1'h1);
    for (i = 0; i < 4; i++) begin
      power_up(i[0], 1'h0);
      @(posedge clk); sw <= i[1];
      init_exit();
      chk(hwc, i[1]);
      wd_fail(1, i[0]);
      recover(!i[1]);
      wd_fail(2, i[0]);
      recover(1'h0);
    end
    for (i = 0; i < 2; i++) begin
      power_up(i[0], 1'h0);
      init_exit();
      ov_event(1'h0, i[0]);
      ov_event(1'h1, i[0]);
      recover(1'h0);
    end
    power_up(1'h0, 1'h0);
    fo_and_wake();
    timeout_relatch();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- common/fcin_pkg.sv ----
// Purpose: shared constants for the failure-configuration and init/normal controller
// Assumes: 40 MHz system clock; all times converted to cycles here
// Notes:   figures with no published value are plain defaults
package fcin_pkg;

  // ***************************************************
  // clock
  // ***************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_MHZ       = 40;

  // ***************************************************
  // timing
  // ***************************************************
  // reset delay time, microseconds (plain default)
  localparam int RD_US         = 10000;
  localparam int RD_CYC_DFLT   = RD_US * CLK_MHZ;
  // long open window of the watchdog, milliseconds (plain default)
  localparam int LW_MS         = 200;
  localparam int LW_CYC_DFLT   = LW_MS * 1000 * CLK_MHZ;
  // continuous config filter time, least time so rounded up
  localparam int CFG_F_NS      = 1000;
  localparam int FILT_CYC      = (CFG_F_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // interrupt pulse width, rounded up
  localparam int INT_PULSE_NS  = 2000;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************
  // widths and reset values
  // ***************************************************
  localparam int CNT_W         = 24;
  localparam int FILT_W        = 8;
  localparam int INT_W         = 7;
  localparam int WAKE_W        = 6;
  localparam logic [1:0] WD_CNT_MAX = 2'h2;
  localparam logic       LATCHED_PIN_CONFIG_BIT_DFLT  = 1'h0;

  // ***************************************************
  // operating modes
  // ***************************************************
  typedef enum logic [1:0] {
    MD_INIT     = 2'h0,
    MD_NORMAL   = 2'h1,
    MD_RESTART  = 2'h2,
    MD_FAILSAFE = 2'h3
  } fcin_mode_e;

endpackage

// ---- design/fcin_cfg_filter.sv ----
// Purpose: continuous stability filter on the config/interrupt pin level
// Assumes: level is already synchronised to CLK
// Notes:   stable drops the cycle after any change of level
`timescale 1ns/100ps
`default_nettype none
module fcin_cfg_filter
  import fcin_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // filter
  input  wire logic run,
  input  wire logic level,
  output var  logic stable,
  output var  logic value
);

  typedef struct packed {
    logic              prev;
    logic [FILT_W-1:0] cnt;
    logic              stable;
    logic              value;
  } fcin_filt_s;

  fcin_filt_s st_r;
  fcin_filt_s st_nxt;

  // ***************************************************
  // filter
  // ***************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = level;
    if (!run || level != st_r.prev) begin
      // a glitch restarts the full filter time
      st_nxt.cnt    = '0;
      st_nxt.stable = 1'h0;
    end else if (st_r.cnt == FILT_W'(FILT_CYC - 1)) begin
      st_nxt.stable = 1'h1;
      st_nxt.value  = level;
    end else begin
      st_nxt.cnt = st_r.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable = st_r.stable;
  assign value  = st_r.value;

  a_filt_glitch_clear: assert property (@(posedge clk) disable iff (rst)
    (run && level != st_r.prev) |=> !stable)
    else $error("filter kept stable after a level change");

endmodule
`default_nettype wire

// ---- design/fcin_ctrl.sv ----
// Purpose: start-up config latch, failure reaction, init exit and normal defaults
// Assumes: RST is the power-on reset; host-side strobes are on CLK
// Notes:   supply comparators and the config pin are asynchronous and synchronised
//
// Summary of operation
// - during reset delay weakly pull config pin low and filter its level
// - latch hardware config bit from filtered pin at reset output rise
// - while power-on flag set, repeat pull-down and latch every reset
// - no stable pin level during sampling latches config bit as zero
// - hardware bit one: watchdog failure restarts; fail outputs by software bit or at the second failure
// - hardware bit zero, software bit one: watchdog failure goes fail-safe with fail outputs
// - both bits zero: first failure restarts, second goes fail-safe
// - every watchdog failure asserts the reset output
// - overvoltage with reset enable and hardware one: flag, fail outputs, restart
// - overvoltage with reset enable and hardware zero: flag, fail outputs, fail-safe
// - overvoltage without reset enable only sets the flag
// - software and latched pin config bits are both readable
// - latched config persists until power-on reset
// - in init any host command moves to normal mode
// - no trigger before long window ends records failure and restarts
// - wake events are ignored and dropped in init
// - reset held low below threshold at power-up, no undervoltage or fail
// - wake in normal pulses interrupt, mode unchanged
// - normal entry turns second regulator and switches off; from init more off
// - fail outputs inactive in normal unless kept from restart
// - the test bit drives the fail outputs in normal only
// - after power-on start in init with long open window
`timescale 1ns/100ps
`default_nettype none
module fcin_ctrl
  import fcin_pkg::*;
#(
  parameter logic [CNT_W-1:0] RD_CYC = CNT_W'(RD_CYC_DFLT),
  parameter logic [CNT_W-1:0] LW_CYC = CNT_W'(LW_CYC_DFLT)
)(
  // clock and power-on reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // supply comparators, asynchronous
  input  wire logic              MAIN_ABOVE_RT,
  input  wire logic              MAIN_OV,
  // config/interrupt pin, open drain
  input  wire logic              CFG_INT_IN,
  output var  logic              CFG_INT_OUT,
  output var  logic              CFG_INT_OE,
  // host strobes and software bits
  input  wire logic              SPI_CMD_STB,
  input  wire logic              WD_TRIG,
  input  wire logic              WD_FAIL,
  input  wire logic              FLAG_CLR,
  input  wire logic              POR_FLAG,
  input  wire logic              SW_CFG,
  input  wire logic              MAIN_OV_RST_EN,
  input  wire logic              FO_TEST,
  // wake detections
  input  wire logic [WAKE_W-1:0] WAKE_EVT,
  // reset and fail outputs
  output var  logic              RESET_OUT_N,
  output var  logic              FAIL_OUT_N,
  // status
  output var  logic [1:0]        MODE,
  output var  logic              HARDWARE_CONTROL_REG_CFG,
  output var  logic              WK_LVL_LATCHED_PIN_CONFIG_BIT,
  output var  logic              MAIN_OV_FLAG,
  output var  logic              MAIN_UV_FLAG,
  output var  logic [1:0]        WD_FAIL_CNT,
  // normal-entry defaults
  output var  logic              REG2_HS_OFF,
  output var  logic              REG3_CAN_LIN_OFF
);

  typedef struct packed {
    logic             rt1;
    logic             rt2;
    logic             ov1;
    logic             ov2;
    logic             ov_prev;
    logic             pin1;
    logic             pin2;
    fcin_mode_e       mode;
    logic             ro;
    logic [CNT_W-1:0] dly;
    logic [CNT_W-1:0] win;
    logic             win_run;
    logic             latched;
    logic             latched_pin_config_bit;
    logic             sw_cfg;
    logic             fo;
    logic             fail_n;
    logic [1:0]       wd_cnt;
    logic             ov_flag;
    logic             uv_flag;
    logic [INT_W-1:0] int_cnt;
    logic             pd;
    logic             int_oe;
    logic             reg2_off;
    logic             reg3_off;
  } fcin_state_s;

  fcin_state_s st_r;
  fcin_state_s st_nxt;
  logic        flt_stable;
  logic        flt_value;
  logic        ov_hit;
  logic        wd_ev;
  logic        ro_rise;
  logic [1:0]  cnt_new;

  // ***************************************************
  // config pin filter
  // ***************************************************
  fcin_cfg_filter u_filt (
    .clk    (CLK),
    .rst    (RST),
    .run    (st_r.pd),
    .level  (st_r.pin2),
    .stable (flt_stable),
    .value  (flt_value)
  );

  assign ov_hit = st_r.ov2 & ~st_r.ov_prev;

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    st_nxt          = st_r;
    wd_ev           = 1'h0;
    ro_rise         = 1'h0;
    cnt_new         = st_r.wd_cnt;
    // only the second stage reads the first
    st_nxt.rt1      = MAIN_ABOVE_RT;
    st_nxt.rt2      = st_r.rt1;
    st_nxt.ov1      = MAIN_OV;
    st_nxt.ov2      = st_r.ov1;
    st_nxt.ov_prev  = st_r.ov2;
    st_nxt.pin1     = CFG_INT_IN;
    st_nxt.pin2     = st_r.pin1;
    st_nxt.sw_cfg   = SW_CFG;
    st_nxt.reg2_off = 1'h0;
    st_nxt.reg3_off = 1'h0;
    if (st_r.int_cnt != '0) begin
      st_nxt.int_cnt = st_r.int_cnt - INT_W'(1);
    end
    // clear first so that a set in the same cycle wins
    if (FLAG_CLR) begin
      st_nxt.ov_flag = 1'h0;
      st_nxt.uv_flag = 1'h0;
      st_nxt.wd_cnt  = 2'h0;
      cnt_new        = 2'h0;
      if (st_r.mode == MD_NORMAL) begin
        st_nxt.fo = 1'h0;
      end
    end
    case (st_r.mode)
      MD_INIT: begin
        // wake events fall through untouched here
        if (!st_r.ro) begin
          // no undervoltage flag and no fail output during the ramp
          if (!st_r.rt2) begin
            st_nxt.dly = '0;
          end else if (st_r.dly == RD_CYC - CNT_W'(1)) begin
            ro_rise        = 1'h1;
            st_nxt.win     = '0;
            st_nxt.win_run = 1'h1;
          end else begin
            st_nxt.dly = st_r.dly + CNT_W'(1);
          end
        end else begin
          if (WD_TRIG) begin
            st_nxt.win_run = 1'h0;
          end else if (st_r.win_run) begin
            // the host owns the trigger inside the window
            if (st_r.win == LW_CYC - CNT_W'(1)) begin
              wd_ev = 1'h1;
            end else begin
              st_nxt.win = st_r.win + CNT_W'(1);
            end
          end
          if (SPI_CMD_STB && !wd_ev) begin
            st_nxt.mode     = MD_NORMAL;
            st_nxt.reg2_off = 1'h1;
            st_nxt.reg3_off = 1'h1;
          end
        end
      end
      MD_NORMAL: begin
        if (!st_r.rt2) begin
          st_nxt.uv_flag = 1'h1;
          st_nxt.mode    = MD_RESTART;
          st_nxt.ro      = 1'h0;
          st_nxt.dly     = '0;
        end else begin
          wd_ev = WD_FAIL;
          if (|WAKE_EVT) begin
            st_nxt.int_cnt = INT_W'(INT_PULSE_CYC);
          end
        end
      end
      MD_RESTART: begin
        if (!st_r.rt2) begin
          st_nxt.dly = '0;
        end else if (st_r.dly == RD_CYC - CNT_W'(1)) begin
          // fail outputs are left as they stand
          ro_rise         = 1'h1;
          st_nxt.mode     = MD_NORMAL;
          st_nxt.reg2_off = 1'h1;
        end else begin
          st_nxt.dly = st_r.dly + CNT_W'(1);
        end
      end
      MD_FAILSAFE: begin
        // main regulator off; only a wake brings it back
        if (|WAKE_EVT) begin
          st_nxt.mode = MD_RESTART;
          st_nxt.dly  = '0;
        end
      end
      default: begin
        st_nxt.mode = MD_INIT;
      end
    endcase
    // watchdog failure reaction
    if (wd_ev) begin
      cnt_new       = (cnt_new == WD_CNT_MAX) ? WD_CNT_MAX : cnt_new + 2'h1;
      st_nxt.wd_cnt = cnt_new;
      st_nxt.ro     = 1'h0;
      st_nxt.dly    = '0;
      if (st_r.sw_cfg || cnt_new == WD_CNT_MAX) begin
        st_nxt.fo = 1'h1;
      end
      if (st_r.mode == MD_INIT || st_r.latched_pin_config_bit) begin
        st_nxt.mode = MD_RESTART;
      end else if (!st_r.sw_cfg && cnt_new != WD_CNT_MAX) begin
        st_nxt.mode = MD_RESTART;
      end else begin
        st_nxt.mode = MD_FAILSAFE;
      end
    end
    // overvoltage reaction while the main regulator is on
    if (ov_hit && st_r.mode != MD_FAILSAFE) begin
      st_nxt.ov_flag = 1'h1;
      if (MAIN_OV_RST_EN) begin
        st_nxt.fo   = 1'h1;
        st_nxt.ro   = 1'h0;
        st_nxt.dly  = '0;
        st_nxt.mode = st_r.latched_pin_config_bit ? MD_RESTART : MD_FAILSAFE;
      end
    end
    // configuration latch on the reset output rise
    if (ro_rise && st_nxt.ro == 1'h0 && st_nxt.mode != MD_FAILSAFE) begin
      st_nxt.ro = 1'h1;
      if (!st_r.latched || POR_FLAG) begin
        // unstable pin gives zero
        st_nxt.latched_pin_config_bit    = flt_stable ? flt_value : LATCHED_PIN_CONFIG_BIT_DFLT;
        st_nxt.latched = 1'h1;
      end
    end
    // weak pull-down during the delay only while a latch is still due
    st_nxt.pd     = ~st_nxt.ro & st_r.rt2 & (~st_r.latched | POR_FLAG);
    st_nxt.int_oe = st_nxt.pd | (st_nxt.int_cnt != '0);
    // test bit acts in normal mode only; it cannot hide a real failure
    st_nxt.fail_n = ~(st_nxt.fo | (st_nxt.mode == MD_NORMAL & FO_TEST));
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r        <= '0;
      st_r.mode   <= MD_INIT;
      st_r.fail_n <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign CFG_INT_OUT      = 1'h0;
  assign CFG_INT_OE       = st_r.int_oe;
  assign RESET_OUT_N      = st_r.ro;
  assign FAIL_OUT_N       = st_r.fail_n;
  assign MODE             = st_r.mode;
  assign HARDWARE_CONTROL_REG_CFG      = st_r.sw_cfg;
  assign WK_LVL_LATCHED_PIN_CONFIG_BIT      = st_r.latched_pin_config_bit;
  assign MAIN_OV_FLAG     = st_r.ov_flag;
  assign MAIN_UV_FLAG     = st_r.uv_flag;
  assign WD_FAIL_CNT      = st_r.wd_cnt;
  assign REG2_HS_OFF      = st_r.reg2_off;
  assign REG3_CAN_LIN_OFF = st_r.reg3_off;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_ramp_ro_low: assert property (
    (st_r.mode == MD_INIT && !st_r.ro && !st_r.rt2) |=> !RESET_OUT_N && !MAIN_UV_FLAG && FAIL_OUT_N)
    else $error("reset output or flags moved below threshold");

  a_init_no_wake: assert property (
    (st_r.mode == MD_INIT) |-> (st_r.int_cnt == '0))
    else $error("wake kept in init");

  a_init_cmd_exit: assert property (
    (st_r.mode == MD_INIT && st_r.ro && SPI_CMD_STB && !ov_hit
     && (WD_TRIG || !(st_r.win_run && st_r.win == LW_CYC - CNT_W'(1))))
    |=> MODE == MD_NORMAL && REG3_CAN_LIN_OFF && REG2_HS_OFF)
    else $error("host command did not leave init");

  a_wake_pulse: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && |WAKE_EVT && !WD_FAIL && !ov_hit)
    |=> CFG_INT_OE && MODE == MD_NORMAL ##1 CFG_INT_OE)
    else $error("wake in normal gave no interrupt pulse");

  a_wd_ro_low: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && WD_FAIL) |=> !RESET_OUT_N ##1 !RESET_OUT_N)
    else $error("watchdog failure left reset released");

  a_hw1_restart: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && WD_FAIL && st_r.latched_pin_config_bit && st_r.sw_cfg)
    |=> MODE == MD_RESTART && !FAIL_OUT_N)
    else $error("config one did not restart with fail outputs");

  a_hw0_failsafe: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && WD_FAIL && !st_r.latched_pin_config_bit && st_r.sw_cfg)
    |=> MODE == MD_FAILSAFE && !FAIL_OUT_N)
    else $error("config two did not go fail-safe");

  a_cfg4_first: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && WD_FAIL && !st_r.latched_pin_config_bit && !st_r.sw_cfg && !FLAG_CLR
     && st_r.wd_cnt == 2'h0 && !(ov_hit && MAIN_OV_RST_EN))
    |=> MODE == MD_RESTART && WD_FAIL_CNT == 2'h1 && (FAIL_OUT_N == !$past(st_r.fo)))
    else $error("config four first failure misrouted");

  a_ov_flag_only: assert property (
    (st_r.mode == MD_NORMAL && st_r.rt2 && ov_hit && !MAIN_OV_RST_EN && !WD_FAIL)
    |=> MAIN_OV_FLAG && MODE == MD_NORMAL && RESET_OUT_N)
    else $error("overvoltage without enable changed the mode");

  a_cfg_persist: assert property (
    (st_r.latched && !POR_FLAG) |=> $stable(WK_LVL_LATCHED_PIN_CONFIG_BIT))
    else $error("latched config changed without power-on flag");

endmodule
`default_nettype wire
